// ==== verilog/glpc_consts.vh ====
`ifndef GLPC_CONSTS_VH
`define GLPC_CONSTS_VH
`define GLPC_OFS_CFG 8'h88
`define GLPC_OFS_IRQ_STS 8'h8c
`define GLPC_OFS_IRQ_EN 8'h90
`define GLPC_LED_LSB 28
`define GLPC_POL_LSB 24
`define GLPC_FUNC_LSB 20
`define GLPC_BUF_LSB 16
`define GLPC_DIR_LSB 8
`define GLPC_OUT_ONLY_LSB 3
`define GLPC_VAL_LSB 0
`define GLPC_IRQ_LSB 0
`define GLPC_CFG_RESET 32'h00000000
`define GLPC_LED_RESET 3'h0
`define GLPC_POL_RESET 3'h0
`define GLPC_FUNC_RESET 3'h0
`define GLPC_BUF_RESET 3'h0
`define GLPC_DIR_RESET 3'h0
`define GLPC_OUT_ONLY_RESET 2'h0
`define GLPC_VAL_RESET 3'h0
`define GLPC_EN_RESET 3'h0
`define GLPC_STS_RESET 3'h0
`define GLPC_FUNC_ROM 3'h0
`define GLPC_FUNC_OUT_AB 3'h1
`define GLPC_FUNC_OUT_A_RXDV 3'h3
`define GLPC_FUNC_TXEN_OUT_B 3'h5
`define GLPC_FUNC_TXEN_RXDV 3'h6
`define GLPC_FUNC_CLKS 3'h7
`define GLPC_CLK_PERIOD_NS 10
`define GLPC_MIN_LEVEL_NS 40
`define GLPC_MIN_LEVEL_CYC ((`GLPC_MIN_LEVEL_NS + `GLPC_CLK_PERIOD_NS - 1) / `GLPC_CLK_PERIOD_NS)
`endif

// ==== verilog/glpc_gpio_led_pin_config.v ====
`timescale 1ns/1ps
`default_nettype none
`include "glpc_consts.vh"
module glpc_gpio_led_pin_config (
  input wire mclk_i,
  input wire resetn_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  output reg irq_o,
  input wire [2:0] gpio_in_i,
  output reg [2:0] gpio_out_o,
  output reg [2:0] gpio_oe_o,
  input wire [2:0] led_sig_i,
  input wire rom_data_in_i,
  output reg rom_data_out_o,
  output reg rom_data_oe_o,
  input wire rom_data_drv_i,
  input wire rom_data_drv_oe_i,
  input wire rom_clk_drv_i,
  output reg rom_clock_pin_o,
  output reg rom_data_rx_o,
  input wire phy_rx_dv_i,
  input wire phy_tx_clk_i,
  input wire phy_rx_clk_i,
  input wire mac_tx_en_i
);

////////////////////////////////////////////////////////////////////////////////

reg [2:0] led_select_bits;
reg [2:0] pin_irq_level_sel;
reg [2:0] serial_rom_pin_func;
reg [2:0] pin_driver_type;
reg [2:0] pin_direction;
reg [1:0] output_only_value;
reg [2:0] pin_value;
reg [2:0] irq_status_reg;
reg [2:0] pin_irq_enable;
reg [2:0] sync1;
reg [2:0] sync2;
reg [2:0] sync3;
reg [2:0] level_now;
reg [2:0] level_cnt0;
reg [2:0] level_cnt1;
reg [2:0] level_cnt2;
reg rom_in1;
reg rom_in2;
reg rom_in3;

wire [31:0] cfg_rd;
wire [2:0] qual;
wire [2:0] irq_hit;
wire cfg_wr;
wire sts_wr;
wire en_wr;
wire [2:0] sts_clr;
reg [31:0] next_rdata;
reg [2:0] next_out;
reg [2:0] next_oe;
reg next_data_out;
reg next_data_oe;
reg next_clk;

function glpc_hit;
  input [7:0] addr;
  input [7:0] ofs;
  begin
    glpc_hit = (addr == ofs);
  end
endfunction

assign cfg_wr = wr_i && glpc_hit(addr_i, `GLPC_OFS_CFG);
assign sts_wr = wr_i && glpc_hit(addr_i, `GLPC_OFS_IRQ_STS);
assign en_wr = wr_i && glpc_hit(addr_i, `GLPC_OFS_IRQ_EN);

// Reserved positions are zero in the read image.
assign cfg_rd = {1'b0,
                 led_select_bits,
                 1'b0,
                 pin_irq_level_sel,
                 1'b0,
                 serial_rom_pin_func,
                 1'b0,
                 pin_driver_type,
                 5'h00,
                 pin_direction,
                 3'h0,
                 output_only_value,
                 level_now};

////////////////////////////////////////////////////////////////////////////////
// Configuration and interrupt registers.

always @(posedge mclk_i) begin
  if (!resetn_i) begin
    led_select_bits <= `GLPC_LED_RESET;
    pin_irq_level_sel <= `GLPC_POL_RESET;
    serial_rom_pin_func <= `GLPC_FUNC_RESET;
    pin_driver_type <= `GLPC_BUF_RESET;
    pin_direction <= `GLPC_DIR_RESET;
    output_only_value <= `GLPC_OUT_ONLY_RESET;
    pin_value <= `GLPC_VAL_RESET;
    pin_irq_enable <= `GLPC_EN_RESET;
  end else begin
    // Only the defined fields are stored, so reserved bits drop what is written.
    if (cfg_wr) begin
      led_select_bits <= wdata_i[`GLPC_LED_LSB +: 3];
      pin_irq_level_sel <= wdata_i[`GLPC_POL_LSB +: 3];
      serial_rom_pin_func <= wdata_i[`GLPC_FUNC_LSB +: 3];
      pin_driver_type <= wdata_i[`GLPC_BUF_LSB +: 3];
      pin_direction <= wdata_i[`GLPC_DIR_LSB +: 3];
      output_only_value <= wdata_i[`GLPC_OUT_ONLY_LSB +: 2];
      pin_value <= wdata_i[`GLPC_VAL_LSB +: 3];
    end
    if (en_wr) begin
      pin_irq_enable <= wdata_i[`GLPC_IRQ_LSB +: 3];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt status and request.

// A level that matches its polarity keeps re-setting the bit, so it wins over a clear.
assign irq_hit = ~(qual ^ pin_irq_level_sel) & ~led_select_bits;
assign sts_clr = sts_wr ? wdata_i[`GLPC_IRQ_LSB +: 3] : 3'h0;

always @(posedge mclk_i) begin
  if (!resetn_i) begin
    irq_status_reg <= `GLPC_STS_RESET;
  end else begin
    irq_status_reg <= (irq_status_reg & ~sts_clr) | irq_hit;
  end
end

// The request is registered so that the pin never glitches while status bits change.
always @(posedge mclk_i) begin
  if (!resetn_i) begin
    irq_o <= 1'b0;
  end else begin
    irq_o <= |(irq_status_reg & pin_irq_enable);
  end
end

////////////////////////////////////////////////////////////////////////////////
// Register read port.

always @* begin
  next_rdata = 32'h00000000;
  case (addr_i)
    `GLPC_OFS_CFG: next_rdata = cfg_rd;
    `GLPC_OFS_IRQ_STS: next_rdata = {29'h0, irq_status_reg};
    `GLPC_OFS_IRQ_EN: next_rdata = {29'h0, pin_irq_enable};
    default: next_rdata = 32'h00000000;
  endcase
end

always @(posedge mclk_i) begin
  if (!resetn_i) begin
    rdata_o <= 32'h00000000;
  end else begin
    rdata_o <= rd_i ? next_rdata : 32'h00000000;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Pin input synchronisers and level qualification.

// The chains keep sampling through reset, so they already hold the idle pin levels when it
// ends and a pulled-up pin does not look like a fresh low level to the interrupt logic.
always @(posedge mclk_i) begin
  sync1 <= gpio_in_i;
  sync2 <= sync1;
  sync3 <= sync2;
end

always @(posedge mclk_i) begin
  rom_in1 <= rom_data_in_i;
  rom_in2 <= rom_in1;
  rom_in3 <= rom_in2;
end

// A change counts only once the second and third stages agree.
always @(posedge mclk_i) begin
  if (!resetn_i) begin
    level_now <= sync3;
  end else begin
    level_now <= (sync2 & sync3) | (level_now & (sync2 | sync3));
  end
end

function [2:0] glpc_count;
  input [2:0] cnt;
  input same;
  begin
    if (!same) begin
      glpc_count = 3'h0;
    end else if (cnt < `GLPC_MIN_LEVEL_CYC) begin
      glpc_count = cnt + 3'h1;
    end else begin
      glpc_count = cnt;
    end
  end
endfunction

function glpc_qual;
  input [2:0] cnt;
  input pol;
  begin
    if (cnt >= `GLPC_MIN_LEVEL_CYC) begin
      glpc_qual = pol;
    end else begin
      glpc_qual = ~pol;
    end
  end
endfunction

// A level counts for interrupts only after it has held for the minimum time.
always @(posedge mclk_i) begin
  if (!resetn_i) begin
    level_cnt0 <= 3'h0;
    level_cnt1 <= 3'h0;
    level_cnt2 <= 3'h0;
  end else begin
    level_cnt0 <= glpc_count(level_cnt0, level_now[0] == pin_irq_level_sel[0]);
    level_cnt1 <= glpc_count(level_cnt1, level_now[1] == pin_irq_level_sel[1]);
    level_cnt2 <= glpc_count(level_cnt2, level_now[2] == pin_irq_level_sel[2]);
  end
end

assign qual = {glpc_qual(level_cnt2, pin_irq_level_sel[2]),
               glpc_qual(level_cnt1, pin_irq_level_sel[1]),
               glpc_qual(level_cnt0, pin_irq_level_sel[0])};

////////////////////////////////////////////////////////////////////////////////
// Pin drivers and multiplexer.

// Open-drain is drive-low or release; the board pull-up supplies the high level.
integer i;
always @* begin
  next_out = 3'h0;
  next_oe = 3'h0;
  for (i = 0; i < 3; i = i + 1) begin
    if (led_select_bits[i]) begin
      next_out[i] = led_sig_i[i];
      next_oe[i] = 1'b1;
    end else if (pin_direction[i]) begin
      if (pin_driver_type[i]) begin
        next_out[i] = pin_value[i];
        next_oe[i] = 1'b1;
      end else begin
        next_out[i] = 1'b0;
        next_oe[i] = ~pin_value[i];
      end
    end
  end
end

// Every defined function but serial memory use drives the data pin as an output.
always @* begin
  next_data_out = 1'b0;
  next_data_oe = 1'b1;
  next_clk = 1'b0;
  case (serial_rom_pin_func)
    `GLPC_FUNC_ROM: begin
      next_data_out = rom_data_drv_i;
      next_data_oe = rom_data_drv_oe_i;
      next_clk = rom_clk_drv_i;
    end
    `GLPC_FUNC_OUT_AB: begin
      next_data_out = output_only_value[0];
      next_clk = output_only_value[1];
    end
    `GLPC_FUNC_OUT_A_RXDV: begin
      next_data_out = output_only_value[0];
      next_clk = phy_rx_dv_i;
    end
    `GLPC_FUNC_TXEN_OUT_B: begin
      next_data_out = mac_tx_en_i;
      next_clk = output_only_value[1];
    end
    `GLPC_FUNC_TXEN_RXDV: begin
      next_data_out = mac_tx_en_i;
      next_clk = phy_rx_dv_i;
    end
    `GLPC_FUNC_CLKS: begin
      next_data_out = phy_tx_clk_i;
      next_clk = phy_rx_clk_i;
    end
    default: begin
      // Reserved codes park both pins low and undriven on the data pin.
      next_data_oe = 1'b0;
    end
  endcase
end

always @(posedge mclk_i) begin
  if (!resetn_i) begin
    gpio_out_o <= 3'h0;
    gpio_oe_o <= 3'h0;
  end else begin
    gpio_out_o <= next_out;
    gpio_oe_o <= next_oe;
  end
end

always @(posedge mclk_i) begin
  if (!resetn_i) begin
    rom_data_out_o <= 1'b0;
    rom_data_oe_o <= 1'b0;
    rom_clock_pin_o <= 1'b0;
  end else begin
    rom_data_out_o <= next_data_out;
    rom_data_oe_o <= next_data_oe;
    rom_clock_pin_o <= next_clk;
  end
end

// The received level only moves when two synchroniser stages agree.
always @(posedge mclk_i) begin
  if (!resetn_i) begin
    rom_data_rx_o <= 1'b0;
  end else begin
    rom_data_rx_o <= (rom_in2 == rom_in3) ? rom_in3 : rom_data_rx_o;
  end
end

endmodule
`default_nettype wire

// ==== tb/glpc_props_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module glpc_props (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic irq_o,
  input wire logic [2:0] gpio_out_o,
  input wire logic [2:0] gpio_oe_o,
  input wire logic [2:0] led_sig_i,
  input wire logic rom_data_out_o,
  input wire logic rom_data_oe_o,
  input wire logic rom_clock_pin_o,
  input wire logic rom_data_drv_i,
  input wire logic rom_data_drv_oe_i,
  input wire logic rom_clk_drv_i,
  input wire logic phy_rx_dv_i,
  input wire logic phy_tx_clk_i,
  input wire logic phy_rx_clk_i,
  input wire logic mac_tx_en_i
);
  logic [31:0] cfg;
  logic [2:0] en;
  logic [2:0] em;
  wire [2:0] l = cfg[30:28];
  wire [2:0] po = l | cfg[10:8] & (cfg[18:16] | ~cfg[2:0]);
  wire [2:0] pd = l & led_sig_i | ~l & cfg[10:8] & cfg[18:16] & cfg[2:0];
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cfg <= 32'h0;
      en <= 3'h0;
    end else if (wr_i && addr_i == 8'h88) begin
      cfg <= wdata_i & 32'h7777071f;
    end else if (wr_i && addr_i == 8'h90) begin
      en <= wdata_i[2:0];
    end
  end
  always_comb begin
    case (cfg[22:20])
      3'h0: em = {rom_data_drv_i & rom_data_drv_oe_i, rom_data_drv_oe_i, rom_clk_drv_i};
      3'h1: em = {cfg[3], 1'b1, cfg[4]};
      3'h3: em = {cfg[3], 1'b1, phy_rx_dv_i};
      3'h5: em = {mac_tx_en_i, 1'b1, cfg[4]};
      3'h6: em = {mac_tx_en_i, 1'b1, phy_rx_dv_i};
      3'h7: em = {phy_tx_clk_i, 1'b1, phy_rx_clk_i};
      default: em = 3'h0;
    endcase
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  unmapped_rd_a: assert property (rd_i && addr_i == 8'h0 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  cfg_read_a: assert property (rd_i && addr_i == 8'h88 |=> rdata_o[31:3] == $past(cfg[31:3]))
    else $error("config read wrong");
  pin_oe_a: assert property (1 |=> gpio_oe_o == $past(po))
    else $error("pin enable wrong");
  pin_out_a: assert property (1 |=> (gpio_out_o & gpio_oe_o) == $past(pd))
    else $error("pin drive wrong");
  input_pin_a: assert property (l == 3'h0 && cfg[10:8] == 3'h0 |=> gpio_oe_o == 3'h0)
    else $error("input pin driven");
  rom_data_a: assert property (1 |=> {rom_data_out_o & rom_data_oe_o, rom_data_oe_o} == $past(em[2:1]))
    else $error("data pin wrong");
  rom_clock_a: assert property (1 |=> rom_clock_pin_o == $past(em[0]))
    else $error("clock pin wrong");
  irq_gate_a: assert property (irq_o |-> $past(en) != 3'h0)
    else $error("interrupt without enable");
  cover property (rd_i && addr_i == 8'h8c);
  cover property ($fell(irq_o));
  cover property (cfg[22:20] == 3'h7);
endmodule
bind glpc_gpio_led_pin_config glpc_props i_props (
  .mclk_i(mclk_i),
  .resetn_i(resetn_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .irq_o(irq_o),
  .gpio_out_o(gpio_out_o),
  .gpio_oe_o(gpio_oe_o),
  .led_sig_i(led_sig_i),
  .rom_data_out_o(rom_data_out_o),
  .rom_data_oe_o(rom_data_oe_o),
  .rom_clock_pin_o(rom_clock_pin_o),
  .rom_data_drv_i(rom_data_drv_i),
  .rom_data_drv_oe_i(rom_data_drv_oe_i),
  .rom_clk_drv_i(rom_clk_drv_i),
  .phy_rx_dv_i(phy_rx_dv_i),
  .phy_tx_clk_i(phy_tx_clk_i),
  .phy_rx_clk_i(phy_rx_clk_i),
  .mac_tx_en_i(mac_tx_en_i)
);
`default_nettype wire

// ==== tb/glpc_board.sv ====
`timescale 1ns/1ps
`default_nettype none
module glpc_board (
  input wire logic [2:0] out_i,
  input wire logic [2:0] oe_i,
  input wire logic [2:0] ext_en_i,
  input wire logic [2:0] ext_val_i,
  input wire logic rom_out_i,
  input wire logic rom_oe_i,
  output logic [2:0] pin_o,
  output logic rom_pin_o
);
  // Pull-ups hold every line high when nobody drives it.
  assign pin_o = oe_i & out_i | ~oe_i & (~ext_en_i | ext_val_i);
  assign rom_pin_o = !rom_oe_i | rom_out_i;
endmodule
`default_nettype wire

// ==== tb/glpc_gpio_led_pin_config_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module glpc_gpio_led_pin_config_tb;
  logic mclk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic irq_o, rom_data_in_i, rom_data_out_o, rom_data_oe_o, rom_clock_pin_o, rom_data_rx_o;
  logic rom_data_drv_i = 1'b0, rom_data_drv_oe_i = 1'b0, rom_clk_drv_i = 1'b0;
  logic phy_rx_dv_i = 1'b0, phy_tx_clk_i = 1'b0, phy_rx_clk_i = 1'b0, mac_tx_en_i = 1'b0;
  logic [7:0] addr_i = 8'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o, d;
  logic [2:0] gpio_in_i, gpio_out_o, gpio_oe_o, led_sig_i = 3'h0, ext_en = 3'h0, ext_val = 3'h0;
  int num_errors = 0;
  int cmp_count = 0;
  glpc_gpio_led_pin_config i_dut (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .irq_o(irq_o),
    .gpio_in_i(gpio_in_i),
    .gpio_out_o(gpio_out_o),
    .gpio_oe_o(gpio_oe_o),
    .led_sig_i(led_sig_i),
    .rom_data_in_i(rom_data_in_i),
    .rom_data_out_o(rom_data_out_o),
    .rom_data_oe_o(rom_data_oe_o),
    .rom_data_drv_i(rom_data_drv_i),
    .rom_data_drv_oe_i(rom_data_drv_oe_i),
    .rom_clk_drv_i(rom_clk_drv_i),
    .rom_clock_pin_o(rom_clock_pin_o),
    .rom_data_rx_o(rom_data_rx_o),
    .phy_rx_dv_i(phy_rx_dv_i),
    .phy_tx_clk_i(phy_tx_clk_i),
    .phy_rx_clk_i(phy_rx_clk_i),
    .mac_tx_en_i(mac_tx_en_i)
  );
  glpc_board i_board (
    .out_i(gpio_out_o),
    .oe_i(gpio_oe_o),
    .ext_en_i(ext_en),
    .ext_val_i(ext_val),
    .rom_out_i(rom_data_out_o),
    .rom_oe_i(rom_data_oe_o),
    .pin_o(gpio_in_i),
    .rom_pin_o(rom_data_in_i)
  );
  initial forever #5 mclk_i = ~mclk_i;
  task cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    @(posedge mclk_i);
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task pin_case(input logic [2:0] dr, bf, v, ee, ev, lv, oe);
    ext_en <= ee;
    ext_val <= ev;
    wr(8'h88, {13'h0, bf, 5'h0, dr, 5'h0, v});
    cyc(8);
    rd(8'h88, d);
    chk("pin oe", {29'h0, gpio_oe_o}, {29'h0, oe});
    chk("pin level", {29'h0, d[2:0]}, {29'h0, lv});
  endtask
  task t_regs;
    cyc(8);
    rd(8'h88, d);
    chk("cfg reset", d, 32'h7);
    rd(8'h0, d);
    chk("unmapped", d, 32'h0);
    led_sig_i <= 3'h5;
    wr(8'h88, 32'hffffffff);
    cyc(8);
    rd(8'h88, d);
    chk("cfg ones", d, 32'h7777071d);
    $display("test regs done");
  endtask
  task t_pins;
    pin_case(3'h7, 3'h3, 3'h2, 3'h0, 3'h0, 3'h2, 3'h7);
    pin_case(3'h7, 3'h3, 3'h5, 3'h0, 3'h0, 3'h5, 3'h3);
    pin_case(3'h0, 3'h0, 3'h0, 3'h7, 3'h6, 3'h6, 3'h0);
    $display("test pins done");
  endtask
  task automatic t_mux;
    logic [2:0] c [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
    logic [2:0] e [6] = '{3'h0, 3'h3, 3'h2, 3'h7, 3'h6, 3'h3};
    logic x [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [2:0] s;
    mac_tx_en_i <= 1'b1;
    phy_rx_clk_i <= 1'b1;
    rom_data_drv_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr(8'h88, {9'h0, c[i], 15'h0, 5'h10});
      cyc(6);
      s = {rom_data_out_o & rom_data_oe_o, rom_data_oe_o, rom_clock_pin_o};
      chk("rom pins", {29'h0, s}, {29'h0, e[i]});
      chk("rom rx", {31'h0, rom_data_rx_o}, {31'h0, x[i]});
    end
    $display("test mux done");
  endtask
  task t_irq;
    ext_en <= 3'h3;
    ext_val <= 3'h0;
    wr(8'h88, 32'h01000000);
    wr(8'h90, 32'h1);
    cyc(8);
    wr(8'h8c, 32'h7);
    ext_val <= 3'h1;
    cyc(6);
    ext_val <= 3'h0;
    cyc(10);
    rd(8'h8c, d);
    chk("status", d, 32'h3);
    chk("irq on", {31'h0, irq_o}, 32'h1);
    wr(8'h90, 32'h0);
    cyc(2);
    chk("irq masked", {31'h0, irq_o}, 32'h0);
    ext_en <= 3'h1;
    cyc(10);
    wr(8'h8c, 32'h7);
    rd(8'h8c, d);
    chk("cleared", d, 32'h0);
    $display("test irq done");
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    resetn_i <= 1'b1;
    t_regs;
    t_pins;
    t_mux;
    t_irq;
    finish_test;
  end
  initial begin
    #100000;
    num_errors++;
    finish_test;
  end
endmodule
`default_nettype wire
